//--- verilog/dm_pointer_pkg.sv
// Constants, types and system register map of the data memory pointer block.
// Assumes a 4-bit core that issues one decoded instruction per cycle on clk_in.
// Functional notes
// RULE1: Bank register 79H, upper two bits zero.
// RULE2: Bank values 0-2 select banks; 3 prohibited.
// RULE3: Bank register reachable whatever bank is selected.
// RULE4: 11-bit index from 7AH[2:0], 7BH, 7CH.
// RULE5: Index enable flag is bit 0 of 7FH.
// RULE6: Row pointer 7AH[2:0]+7BH, enable 7AH bit 3.
// RULE7: Row pointer shares index storage; 7AH[2:1] zero.
// RULE8: Index enable ORs index into bank, row, column.
// RULE9: Listed non-memory instructions never index-modified.
// RULE10: Row pointer enable replaces indirect destination bank, row.
// RULE11: Only indirect transfers use the row pointer.
// RULE12: Index increment is 9-bit, 1FFH wraps to 000H.
// RULE13: Genreg pointer 7DH plus 7EH[3:1], five valid bits.
// RULE14: 7DH part selects bank, 7EH part selects row.
// RULE15: Genreg only rows 0-7 of banks 0, 1.
// RULE16: 7EH bit 0 is decimal flag, kept separately.
// RULE17: Fixed-zero bits ignore writes, read zero.
// RULE18: All pointer bits clear on any reset source.

package dm_pointer_pkg;

	// ----------------------------------------------------------------
	// System register locations
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_BANK_SELECT = 7'h79;
	localparam logic [6:0] ADDR_POINTER_HIGH = 7'h7A;
	localparam logic [6:0] ADDR_POINTER_MIDDLE = 7'h7B;
	localparam logic [6:0] ADDR_INDEX_LOW = 7'h7C;
	localparam logic [6:0] ADDR_GENREG_HIGH = 7'h7D;
	localparam logic [6:0] ADDR_GENREG_LOW = 7'h7E;
	localparam logic [6:0] ADDR_STATUS_WORD = 7'h7F;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int SYS_ADDR_W = 7;
	localparam int NIBBLE_W = 4;
	localparam int BANK_W = 2;
	localparam int DM_BANK_W = 4;
	localparam int DM_ROW_W = 3;
	localparam int DM_COL_W = 4;
	localparam int DM_ADDR_W = DM_BANK_W + DM_ROW_W + DM_COL_W;
	localparam int INDEX_W = 11;
	localparam int INDEX_INC_W = 9;
	localparam int ROW_PTR_W = 7;
	localparam int POS_ROW_PTR_ENABLE = 3;
	localparam int POS_INDEX_ENABLE = 0;
	localparam int POS_DECIMAL_FLAG = 0;

	// ----------------------------------------------------------------
	// Reset values, increment step and read default
	// ----------------------------------------------------------------
	localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
	localparam logic [NIBBLE_W-1:0] NIBBLE_RESET = 4'h0;
	localparam logic [INDEX_INC_W-1:0] INDEX_RESET = 9'h000;
	localparam logic [INDEX_INC_W-1:0] INDEX_ONE = 9'h001;
	localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IC_EXEMPT,
		IC_DM_MANIP,
		IC_GR_INDIRECT,
		IC_INDEX_INC
	} instr_class_e;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [SYS_ADDR_W-1:0] addr;
		logic [NIBBLE_W-1:0] wdata;
	} sysreg_req_s;

	typedef struct packed {
		logic valid;
		instr_class_e cls;
		logic [DM_ADDR_W-1:0] mem_addr;
		logic [DM_ADDR_W-1:0] ind_addr;
		logic [DM_COL_W-1:0] gr_col;
	} instr_req_s;

	typedef struct packed {
		logic valid;
		logic [DM_ADDR_W-1:0] mem_addr;
		logic [DM_ADDR_W-1:0] ind_addr;
		logic [DM_ADDR_W-1:0] gr_addr;
	} addr_result_s;

endpackage : dm_pointer_pkg

//--- verilog/data_memory_address_pointers.sv
// Bank, index, row pointer and general register pointer of the data memory.
// Assumes system register accesses and decoded instructions arrive on clk_in.
`timescale 1ns/1ps
`default_nettype none

module data_memory_address_pointers (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clock_stop_in,
	input wire logic ce_reset_in,
	input wire dm_pointer_pkg::sysreg_req_s sys_req_in,
	input wire dm_pointer_pkg::instr_req_s instr_in,
	output logic [dm_pointer_pkg::NIBBLE_W-1:0] rdata_out,
	output logic rd_hit_out,
	output dm_pointer_pkg::addr_result_s result_out,
	output logic [dm_pointer_pkg::BANK_W-1:0] bank_out,
	output logic [dm_pointer_pkg::INDEX_W-1:0] index_value_out,
	output logic index_modify_enable_out,
	output logic row_pointer_enable_out,
	output logic decimal_flag_out
);
	import dm_pointer_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_sync1_q;
	logic rst_sync2_q;
	logic rst_n;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	assign rst_n = rst_sync2_q;

	// Clock stop and chip-enable clears act like power-on for the system register state, not the output flops
	logic soft_clear;
	assign soft_clear = clock_stop_in | ce_reset_in;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wr_bank;
	logic wr_ptr_high;
	logic wr_ptr_mid;
	logic wr_idx_low;
	logic wr_gr_high;
	logic wr_gr_low;
	logic wr_status;

	// Decoded independently of the bank register value
	assign wr_bank = sys_req_in.wr_en && (sys_req_in.addr == ADDR_BANK_SELECT); // RULE3
	assign wr_ptr_high = sys_req_in.wr_en && (sys_req_in.addr == ADDR_POINTER_HIGH);
	assign wr_ptr_mid = sys_req_in.wr_en && (sys_req_in.addr == ADDR_POINTER_MIDDLE);
	assign wr_idx_low = sys_req_in.wr_en && (sys_req_in.addr == ADDR_INDEX_LOW);
	assign wr_gr_high = sys_req_in.wr_en && (sys_req_in.addr == ADDR_GENREG_HIGH);
	assign wr_gr_low = sys_req_in.wr_en && (sys_req_in.addr == ADDR_GENREG_LOW);
	assign wr_status = sys_req_in.wr_en && (sys_req_in.addr == ADDR_STATUS_WORD);

	// ----------------------------------------------------------------
	// Bank select
	// ----------------------------------------------------------------
	logic [BANK_W-1:0] bank_q;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bank_q <= BANK_RESET; // RULE18
		end else if (soft_clear) begin
			bank_q <= BANK_RESET; // RULE18
		end else if (wr_bank) begin
			// Upper two bits dropped; value 3 is software's to avoid
			bank_q <= sys_req_in.wdata[BANK_W-1:0]; // RULE1 RULE2 RULE17
		end
	end

	// ----------------------------------------------------------------
	// Index register and row pointer storage
	// ----------------------------------------------------------------
	// Only nine index bits exist; bits 10 and 9 are the fixed-zero 7AH[2:1]
	logic [INDEX_INC_W-1:0] index_q;
	logic [INDEX_INC_W-1:0] index_d;
	logic row_ptr_en_q;
	logic index_en_q;
	logic index_inc;

	assign index_inc = instr_in.valid && (instr_in.cls == IC_INDEX_INC);

	always_comb begin
		index_d = index_q;
		if (index_inc) begin
			index_d = index_q + INDEX_ONE; // RULE12
		end
		// Software write to a nibble takes priority over an increment
		if (wr_ptr_high) begin
			index_d[INDEX_INC_W-1] = sys_req_in.wdata[0]; // RULE7 RULE17
		end
		if (wr_ptr_mid) begin
			index_d[INDEX_INC_W-2 -: NIBBLE_W] = sys_req_in.wdata; // RULE4 RULE6
		end
		if (wr_idx_low) begin
			index_d[NIBBLE_W-1:0] = sys_req_in.wdata; // RULE4
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			index_q <= INDEX_RESET; // RULE18
		end else if (soft_clear) begin
			index_q <= INDEX_RESET; // RULE18
		end else begin
			index_q <= index_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			row_ptr_en_q <= 1'b0; // RULE18
		end else if (soft_clear) begin
			row_ptr_en_q <= 1'b0; // RULE18
		end else if (wr_ptr_high) begin
			row_ptr_en_q <= sys_req_in.wdata[POS_ROW_PTR_ENABLE]; // RULE6
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			index_en_q <= 1'b0; // RULE18
		end else if (soft_clear) begin
			index_en_q <= 1'b0; // RULE18
		end else if (wr_status) begin
			index_en_q <= sys_req_in.wdata[POS_INDEX_ENABLE]; // RULE5
		end
	end

	logic [INDEX_W-1:0] index_full;
	logic [ROW_PTR_W-1:0] row_ptr;

	assign index_full = {{(INDEX_W-INDEX_INC_W){1'b0}}, index_q}; // RULE4 RULE7
	assign row_ptr = index_full[INDEX_W-1 -: ROW_PTR_W]; // RULE6 RULE7

	// ----------------------------------------------------------------
	// General register pointer and decimal flag
	// ----------------------------------------------------------------
	logic [BANK_W-1:0] gr_bank_q;
	logic [DM_ROW_W-1:0] gr_row_q;
	logic decimal_q;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gr_bank_q <= BANK_RESET; // RULE18
		end else if (soft_clear) begin
			gr_bank_q <= BANK_RESET; // RULE18
		end else if (wr_gr_high) begin
			gr_bank_q <= sys_req_in.wdata[BANK_W-1:0]; // RULE13 RULE17
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gr_row_q <= 3'h0; // RULE18
		end else if (soft_clear) begin
			gr_row_q <= 3'h0; // RULE18
		end else if (wr_gr_low) begin
			gr_row_q <= sys_req_in.wdata[NIBBLE_W-1:1]; // RULE13 RULE14
		end
	end

	// Own flop so the pointer bits never disturb it
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			decimal_q <= 1'b0;
		end else if (soft_clear) begin
			decimal_q <= 1'b0;
		end else if (wr_gr_low) begin
			decimal_q <= sys_req_in.wdata[POS_DECIMAL_FLAG]; // RULE16
		end
	end

	// ----------------------------------------------------------------
	// Address formation
	// ----------------------------------------------------------------
	logic index_applies;
	logic row_ptr_applies;
	logic [DM_ADDR_W-1:0] mem_addr_d;
	logic [DM_ADDR_W-1:0] ind_addr_d;
	logic [DM_ADDR_W-1:0] gr_addr_d;

	// Exempt and increment instructions see the raw operand address
	assign index_applies = index_en_q &&
		((instr_in.cls == IC_DM_MANIP) || (instr_in.cls == IC_GR_INDIRECT)); // RULE9
	assign row_ptr_applies = row_ptr_en_q && (instr_in.cls == IC_GR_INDIRECT); // RULE11

	always_comb begin
		mem_addr_d = instr_in.mem_addr;
		if (index_applies) begin
			mem_addr_d = instr_in.mem_addr | index_full; // RULE8
		end
	end

	always_comb begin
		ind_addr_d = instr_in.ind_addr;
		if (row_ptr_applies) begin
			ind_addr_d = {row_ptr, instr_in.ind_addr[DM_COL_W-1:0]}; // RULE10
		end
	end

	// Only the low bank bit reaches the address, limiting it to banks 0 and 1
	assign gr_addr_d = {{(DM_BANK_W-1){1'b0}}, gr_bank_q[0], gr_row_q, instr_in.gr_col}; // RULE14 RULE15

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			result_out <= '0;
		end else begin
			result_out.valid <= instr_in.valid && (instr_in.cls != IC_INDEX_INC);
			result_out.mem_addr <= mem_addr_d;
			result_out.ind_addr <= ind_addr_d;
			result_out.gr_addr <= gr_addr_d;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [NIBBLE_W-1:0] rdata_d;
	logic hit_d;

	always_comb begin
		rdata_d = NIBBLE_ZERO;
		hit_d = 1'b1;
		unique case (sys_req_in.addr)
			ADDR_BANK_SELECT: rdata_d = {2'b00, bank_q}; // RULE1 RULE17
			ADDR_POINTER_HIGH: rdata_d = {row_ptr_en_q, 2'b00, index_q[INDEX_INC_W-1]}; // RULE7 RULE17
			ADDR_POINTER_MIDDLE: rdata_d = index_q[INDEX_INC_W-2 -: NIBBLE_W];
			ADDR_INDEX_LOW: rdata_d = index_q[NIBBLE_W-1:0];
			ADDR_GENREG_HIGH: rdata_d = {2'b00, gr_bank_q}; // RULE13 RULE17
			ADDR_GENREG_LOW: rdata_d = {gr_row_q, decimal_q}; // RULE16
			ADDR_STATUS_WORD: rdata_d = {3'b000, index_en_q};
			default: hit_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= NIBBLE_ZERO;
			rd_hit_out <= 1'b0;
		end else begin
			rdata_out <= sys_req_in.rd_en ? rdata_d : NIBBLE_ZERO;
			rd_hit_out <= sys_req_in.rd_en && hit_d;
		end
	end

	// ----------------------------------------------------------------
	// State views
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bank_out <= BANK_RESET;
			index_value_out <= '0;
			index_modify_enable_out <= 1'b0;
			row_pointer_enable_out <= 1'b0;
			decimal_flag_out <= 1'b0;
		end else begin
			bank_out <= bank_q;
			index_value_out <= index_full;
			index_modify_enable_out <= index_en_q;
			row_pointer_enable_out <= row_ptr_en_q;
			decimal_flag_out <= decimal_q;
		end
	end

endmodule : data_memory_address_pointers

`default_nettype wire

//--- testbench/dm_pointer_props.sv
// Port-level checks of the data memory pointer block.
// Assumes binding to data_memory_address_pointers on one clock.
`timescale 1ns/1ps
`default_nettype none

module dm_pointer_props
	import dm_pointer_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clock_stop_in,
	input wire logic ce_reset_in,
	input wire dm_pointer_pkg::sysreg_req_s sys_req_in,
	input wire dm_pointer_pkg::instr_req_s instr_in,
	input wire logic [dm_pointer_pkg::NIBBLE_W-1:0] rdata_out,
	input wire logic rd_hit_out,
	input wire dm_pointer_pkg::addr_result_s result_out,
	input wire logic [dm_pointer_pkg::BANK_W-1:0] bank_out,
	input wire logic [dm_pointer_pkg::INDEX_W-1:0] index_value_out,
	input wire logic index_modify_enable_out,
	input wire logic row_pointer_enable_out,
	input wire logic decimal_flag_out
);
	logic in_map;
	logic rd_at;
	logic ins_at;
	assign in_map = sys_req_in.addr >= ADDR_BANK_SELECT;
	assign rd_at = sys_req_in.rd_en;
	assign ins_at = instr_in.valid;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence s_bank_wr;
		sys_req_in.wr_en && sys_req_in.addr == ADDR_BANK_SELECT && !clock_stop_in && !ce_reset_in;
	endsequence
	sequence s_clear;
		clock_stop_in || ce_reset_in;
	endsequence

	property p_bank_write;
		s_bank_wr |-> ##2 bank_out == $past(sys_req_in.wdata[1:0], 2);
	endproperty
	property p_clear;
		s_clear |-> ##2 (bank_out == 2'h0 && index_value_out == 11'h000 && !index_modify_enable_out
			&& !row_pointer_enable_out);
	endproperty
	property p_rd_miss;
		rd_at && !in_map |=> rdata_out == 4'h0 && !rd_hit_out;
	endproperty
	property p_rd_hit;
		rd_at && in_map |=> rd_hit_out;
	endproperty
	property p_bank_zero;
		rd_at && sys_req_in.addr == ADDR_BANK_SELECT |=> rdata_out[3:2] == 2'h0;
	endproperty
	property p_ptr_zero;
		rd_at && sys_req_in.addr == ADDR_POINTER_HIGH |=> rdata_out[2:1] == 2'h0;
	endproperty
	property p_gr_zero;
		rd_at && sys_req_in.addr == ADDR_GENREG_HIGH |=> rdata_out[3:2] == 2'h0;
	endproperty
	property p_index_or;
		ins_at && instr_in.cls == IC_DM_MANIP |=> result_out.valid && result_out.mem_addr ==
			($past(instr_in.mem_addr) | (index_modify_enable_out ? index_value_out : 11'h000));
	endproperty
	property p_exempt;
		ins_at && instr_in.cls == IC_EXEMPT |=> result_out.mem_addr == $past(instr_in.mem_addr)
			&& result_out.ind_addr == $past(instr_in.ind_addr);
	endproperty
	property p_rowptr;
		ins_at && instr_in.cls == IC_GR_INDIRECT |=> result_out.ind_addr == (row_pointer_enable_out ?
			{index_value_out[10:4], $past(instr_in.ind_addr[3:0])} : $past(instr_in.ind_addr));
	endproperty
	property p_inc_silent;
		ins_at && instr_in.cls == IC_INDEX_INC |=> !result_out.valid;
	endproperty
	property p_gr_rows;
		result_out.valid |-> result_out.gr_addr[10:8] == 3'h0;
	endproperty

	a_bank_write: assert property (p_bank_write) else $error("bank output wrong after write");
	a_clear: assert property (p_clear) else $error("state not cleared");
	a_rd_miss: assert property (p_rd_miss) else $error("unmapped read answered");
	a_rd_hit: assert property (p_rd_hit) else $error("mapped read missed");
	a_bank_zero: assert property (p_bank_zero) else $error("bank upper bits set");
	a_ptr_zero: assert property (p_ptr_zero) else $error("pointer fixed bits set");
	a_gr_zero: assert property (p_gr_zero) else $error("genreg fixed bits set");
	a_index_or: assert property (p_index_or) else $error("index modification wrong");
	a_exempt: assert property (p_exempt) else $error("exempt address modified");
	a_rowptr: assert property (p_rowptr) else $error("row pointer replace wrong");
	a_inc_silent: assert property (p_inc_silent) else $error("increment gave result");
	a_gr_rows: assert property (p_gr_rows) else $error("genreg outside banks 0-1");
endmodule : dm_pointer_props

`default_nettype wire

//--- testbench/cpu_model.sv
// Instruction decoder model: issues register accesses and decoded instructions.
// Assumes answers arrive one cycle after each request.
`timescale 1ns/1ps
`default_nettype none

module cpu_model
	import dm_pointer_pkg::*;
(
	input wire logic clk_in,
	input wire logic [dm_pointer_pkg::NIBBLE_W-1:0] rdata_in,
	input wire dm_pointer_pkg::addr_result_s result_in,
	output dm_pointer_pkg::sysreg_req_s sys_req_out,
	output dm_pointer_pkg::instr_req_s instr_out
);
	initial begin
		sys_req_out = '0;
		instr_out = '0;
	end

	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		@(posedge clk_in);
		sys_req_out <= '{1'b1, 1'b0, a, d};
		@(posedge clk_in);
		sys_req_out <= '0;
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [3:0] d);
		@(posedge clk_in);
		sys_req_out <= '{1'b0, 1'b1, a, 4'h0};
		@(posedge clk_in);
		sys_req_out <= '0;
		#1 d = rdata_in;
	endtask : rd

	task automatic ins(input instr_class_e c, input logic [10:0] m, i, input logic [3:0] g,
		output addr_result_s r);
		@(posedge clk_in);
		instr_out <= '{1'b1, c, m, i, g};
		@(posedge clk_in);
		instr_out <= '0;
		#1 r = result_in;
	endtask : ins
endmodule : cpu_model

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench of the data memory pointer block.
// Assumes cpu_model drives all requests; bench drives clears.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dm_pointer_pkg::*;
	logic clk_in, resetn_in, clock_stop_in, ce_reset_in, rd_hit, ixen, rpen, dec;
	sysreg_req_s sys_req;
	instr_req_s instr;
	addr_result_s res, r;
	logic [3:0] rdata, d;
	logic [1:0] bank;
	logic [10:0] idx;
	int errors, n_compared, cycles;

	data_memory_address_pointers dut (.clk_in(clk_in), .resetn_in(resetn_in), .clock_stop_in(clock_stop_in),
		.ce_reset_in(ce_reset_in), .sys_req_in(sys_req), .instr_in(instr), .rdata_out(rdata),
		.rd_hit_out(rd_hit), .result_out(res), .bank_out(bank), .index_value_out(idx),
		.index_modify_enable_out(ixen), .row_pointer_enable_out(rpen), .decimal_flag_out(dec));
	cpu_model cpu (.clk_in(clk_in), .rdata_in(rdata), .result_in(res), .sys_req_out(sys_req),
		.instr_out(instr));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic chk(input logic [10:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [6:0] a, input logic [3:0] e);
		cpu.rd(a, d);
		chk(d, e);
	endtask : rdchk

	task automatic settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask : settle

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		for (int a = 'h79; a <= 'h7F; a++)
			rdchk(a[6:0], 4'h0);
		rdchk(7'h78, 4'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_bank;
		for (int b = 0; b < 3; b++) begin
			cpu.wr(7'h79, {2'h3, b[1:0]});
			rdchk(7'h79, {2'h0, b[1:0]});
			settle();
			chk(bank, b[1:0]);
		end
		$display("test bank done");
	endtask : t_bank

	task automatic t_ptr;
		cpu.wr(7'h7A, 4'hF);
		cpu.wr(7'h7B, 4'h6);
		cpu.wr(7'h7C, 4'h3);
		cpu.wr(7'h7F, 4'hF);
		rdchk(7'h7A, 4'h9);
		rdchk(7'h7F, 4'h1);
		settle();
		chk(idx, 11'h163);
		chk(ixen, 1'b1);
		chk(rpen, 1'b1);
		$display("test pointer done");
	endtask : t_ptr

	task automatic t_instr;
		cpu.ins(IC_DM_MANIP, 11'h400, 11'h7FF, 4'h0, r);
		chk(r.mem_addr, 11'h563);
		chk(r.ind_addr, 11'h7FF);
		cpu.ins(IC_EXEMPT, 11'h400, 11'h00A, 4'h0, r);
		chk(r.mem_addr, 11'h400);
		cpu.ins(IC_GR_INDIRECT, 11'h000, 11'h00A, 4'h0, r);
		chk(r.ind_addr, 11'h16A);
		cpu.wr(7'h7F, 4'h0);
		cpu.ins(IC_DM_MANIP, 11'h400, 11'h000, 4'h0, r);
		chk(r.mem_addr, 11'h400);
		$display("test instruction done");
	endtask : t_instr

	task automatic t_inc;
		cpu.wr(7'h7A, 4'h9);
		cpu.wr(7'h7B, 4'hF);
		cpu.wr(7'h7C, 4'hF);
		cpu.ins(IC_INDEX_INC, 11'h000, 11'h000, 4'h0, r);
		chk(r.valid, 1'b0);
		settle();
		chk(idx, 11'h000);
		rdchk(7'h7A, 4'h8);
		$display("test increment done");
	endtask : t_inc

	task automatic t_genreg;
		cpu.wr(7'h7D, 4'hF);
		rdchk(7'h7D, 4'h3);
		cpu.wr(7'h7E, 4'hB);
		rdchk(7'h7E, 4'hB);
		settle();
		chk(dec, 1'b1);
		cpu.ins(IC_DM_MANIP, 11'h000, 11'h000, 4'h5, r);
		chk(r.gr_addr, 11'h0D5);
		$display("test genreg done");
	endtask : t_genreg

	task automatic t_clear;
		for (int s = 0; s < 2; s++) begin
			cpu.wr(7'h79, 4'h2);
			cpu.wr(7'h7A, 4'hF);
			cpu.wr(7'h7D, 4'h1);
			cpu.wr(7'h7E, 4'h3);
			cpu.wr(7'h7F, 4'h1);
			@(posedge clk_in);
			clock_stop_in <= (s == 0);
			ce_reset_in <= (s == 1);
			@(posedge clk_in);
			clock_stop_in <= 1'b0;
			ce_reset_in <= 1'b0;
			settle();
			chk(bank, 2'h0);
			chk(idx, 11'h000);
			chk(rpen, 1'b0);
			chk(ixen, 1'b0);
			chk(dec, 1'b0);
			rdchk(7'h7D, 4'h0);
			rdchk(7'h7E, 4'h0);
			cpu.ins(IC_GR_INDIRECT, 11'h000, 11'h00A, 4'h0, r);
			chk(r.ind_addr, 11'h00A);
		end
		$display("test clear done");
	endtask : t_clear

	// ----------------------------------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		resetn_in = 1'b0;
		clock_stop_in = 1'b0;
		ce_reset_in = 1'b0;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		t_reset();
		t_bank();
		t_ptr();
		t_instr();
		t_inc();
		t_genreg();
		t_clear();
		close_out();
	end
endmodule : tb

bind data_memory_address_pointers dm_pointer_props props (.clk_in(clk_in), .resetn_in(resetn_in),
	.clock_stop_in(clock_stop_in), .ce_reset_in(ce_reset_in), .sys_req_in(sys_req_in), .instr_in(instr_in),
	.rdata_out(rdata_out), .rd_hit_out(rd_hit_out), .result_out(result_out), .bank_out(bank_out),
	.index_value_out(index_value_out), .index_modify_enable_out(index_modify_enable_out),
	.row_pointer_enable_out(row_pointer_enable_out), .decimal_flag_out(decimal_flag_out));

`default_nettype wire
